/* rtl/jtf_framer.sv */
/*
  Transmit link framer: transport packing, link state, ILAS, alignment
  character insertion, scrambling and encoding for four lanes.
  Assumes clk is the character clock and that the serializer outside
  shifts each 10-bit symbol out MSB first. The sample source presents a
  whole frame of words on frame_word and holds them until frame_take.
*/
`timescale 1ns/10ps
`include "jtf_regs.svh"
module jtf_framer #(
  parameter int WORDS = 64,  // Sample words per frame, most
  parameter int CONVS = 8    // Virtual converters, most
) (
  input  wire logic           clk,                    // Character clock
  input  wire logic           rstn,                   // Sync reset, low
  input  wire logic [7:0]     reg_addr,               // Register byte address
  input  wire logic [31:0]    reg_wdata,              // Register write data
  input  wire logic           reg_wr,                 // Write strobe
  input  wire logic           reg_rd,                 // Read strobe
  output logic      [31:0]    reg_rdata,              // Read data, next cycle
  input  jtf_pkg::jtf_word_type frame_word [WORDS],   // Frame words in order
  input  wire logic [2:0]     conv_flags [CONVS],     // FD, sysref, overrange
  output logic                frame_take,             // Words taken this edge
  input  wire logic           sync_req_n,             // Receiver sync, low
  output logic      [3:0]     lane_active,            // Lane in use
  output logic      [9:0]     serial_lane_0,          // Lane 0 symbol
  output logic      [9:0]     serial_lane_1,          // Lane 1 symbol
  output logic      [9:0]     serial_lane_2,          // Lane 2 symbol
  output logic      [9:0]     serial_lane_3           // Lane 3 symbol
);
  import jtf_pkg::*;

  localparam int LANES = 4;

  logic [31:0]   link_reg;
  logic [31:0]   ctrl_reg;
  logic [31:0]   stat;
  jtf_state_type state;
  jtf_state_type next_state;
  logic [1:0]    ilas_mf;
  logic [3:0]    f_cnt;
  logic [4:0]    k_cnt;
  logic [14:0]   prbs;
  jtf_word_type  wbuf [WORDS];
  logic [9:0]    sym [LANES];

  // Register decode
  wire sel_link = reg_addr == `JTF_OFF_LINK;
  wire sel_ctrl = reg_addr == `JTF_OFF_CTRL;
  wire sel_stat = reg_addr == `JTF_OFF_STAT;
  wire relink   = reg_wr && sel_ctrl && reg_wdata[`JTF_C_RELINK];

  // Link parameter fields
  wire [1:0] l_raw  = link_reg[`JTF_L_L];
  wire [1:0] m_log  = link_reg[`JTF_L_M];
  wire [2:0] f_log  = link_reg[`JTF_L_F];
  wire       np16   = link_reg[`JTF_L_NP];
  wire [3:0] n_m1   = link_reg[`JTF_L_N];
  wire [1:0] cs     = link_reg[`JTF_L_CS];
  wire [2:0] kcode  = link_reg[`JTF_L_K];

  // Control fields
  wire           scr_en    = ctrl_reg[`JTF_C_SCR];
  wire           tail_prbs = ctrl_reg[`JTF_C_PRBS];
  wire           faci      = ctrl_reg[`JTF_C_FACI];
  jtf_quick_type quick;
  assign quick = jtf_quick_type'(ctrl_reg[`JTF_C_QUICK]);

  // Single-lane quick mode folds the link onto lane 0
  wire [1:0] l_log = (quick == JTF_Q_ONE) ? 2'h0 : l_raw;
  wire       swap  = quick == JTF_Q_SWAP && m_log != 2'h0;

  // Derived S and HD; S = L*F*8 / (M*N') as log2
  wire [3:0] s_num = {2'h0, l_log} + {1'h0, f_log} + 4'h3;
  wire [3:0] s_den = {2'h0, m_log} + 4'h3 + {3'h0, np16};
  wire [2:0] s_log = 3'(s_num - s_den);
  wire       hd    = np16 && f_log == 3'h0;
  wire [4:0] nbits = np16 ? 5'h10 : 5'h08;
  wire [4:0] used  = {1'h0, n_m1} + 5'h01 + {3'h0, cs};

  // Illegal settings hold the link in synchronization
  wire cfg_err = l_raw == 2'h3 || f_log > 3'h4 || n_m1 < 4'h6 ||
                 s_num < s_den || used > nbits;

  // Frame and multiframe boundaries
  wire [3:0] f_max  = 4'((5'h01 << f_log) - 5'h01);
  wire [4:0] k_max  = {kcode, 2'h3};
  wire       f_last = f_cnt >= f_max;
  wire       mf_end = f_last && k_cnt >= k_max;

  // ILAS link configuration fields
  wire [4:0] lm1  = 5'((3'h1 << l_log) - 3'h1);
  wire [4:0] mm1  = 5'((4'h1 << m_log) - 4'h1);
  wire [4:0] sm1  = 5'((7'h01 << s_log) - 7'h01);
  wire [4:0] npm1 = np16 ? 5'h0f : 5'h07;
  wire [7:0] c_l  = {scr_en, 2'h0, lm1};
  wire [7:0] c_n  = {cs, 1'h0, 1'h0, n_m1};
  wire [7:0] c_np = {3'h1, npm1};
  wire [7:0] c_s  = {3'h1, sm1};
  wire [7:0] c_hd = {hd, 7'h00};
  wire [7:0] c_sum = 8'({7'h00, scr_en}) + 8'(lm1) + 8'(f_max) + 8'(k_max) +
                     8'(mm1) + 8'(n_m1) + 8'(cs) + 8'(npm1) + 8'h01 +
                     8'(sm1) + 8'h01 + 8'(hd);

  // Packs one sample into a word: sample, control bits, then tail
  function automatic jtf_word_type jtf_pack(
    input jtf_word_type smp,
    input logic [2:0]   flg,
    input logic [14:0]  rnd,
    input logic [3:0]   nm1,
    input logic [1:0]   ncs,
    input logic         use_rnd
  );
    jtf_word_type w;
    int           top;
    w   = '0;
    top = 15 - int'(nm1);
    for (int p = 0; p < 16; p++) begin
      if (p >= top) begin
        w[p] = smp[p];
      end else if (p >= top - int'(ncs)) begin
        w[p] = flg[2'(top - 1 - p)];
      end else begin
        w[p] = use_rnd & rnd[p[3:0]];
      end
    end
    return w;
  endfunction

  // Link state changes
  always_comb begin
    next_state = state;
    case (state)
      JTF_CGS: begin
        if (sync_req_n && mf_end) begin
          next_state = JTF_ILAS;
        end
      end
      JTF_ILAS: begin
        if (mf_end && ilas_mf == `JTF_ILAS_LAST) begin
          next_state = JTF_DATA;
        end
      end
      default: begin
        next_state = state;
      end
    endcase
    // A sync request, a relink or a bad setting restarts the link
    if (!sync_req_n || relink || cfg_err) begin
      next_state = JTF_CGS;
    end
  end

  // Register writes; link parameters reset to two converters, four lanes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_reg <= `JTF_LINK_RST;
      ctrl_reg <= `JTF_CTRL_RST;
    end else if (reg_wr && sel_link) begin
      link_reg <= reg_wdata & `JTF_LINK_MASK;
    end else if (reg_wr && sel_ctrl) begin
      ctrl_reg <= reg_wdata & `JTF_CTRL_MASK;
    end
  end

  // Status word
  assign stat[`JTF_S_STATE] = state;
  assign stat[`JTF_S_ERR]   = cfg_err;
  assign stat[3]            = 1'b0;
  assign stat[`JTF_S_S]     = s_log;
  assign stat[`JTF_S_HD]    = hd;
  assign stat[`JTF_S_SYNC]  = sync_req_n;
  assign stat[31:9]         = 23'h000000;

  wire [31:0] rd_mux = sel_link ? link_reg : sel_ctrl ? ctrl_reg :
                       sel_stat ? stat : 32'h0000_0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Free-running frame and multiframe counters keep the LMFC
  always_ff @(posedge clk) begin
    if (!rstn) begin
      f_cnt <= 4'h0;
      k_cnt <= 5'h00;
    end else begin
      f_cnt <= f_last ? 4'h0 : f_cnt + 4'h1;
      if (f_last) begin
        k_cnt <= (k_cnt >= k_max) ? 5'h00 : k_cnt + 5'h01;
      end
    end
  end

  // State and ILAS multiframe count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state   <= JTF_CGS;
      ilas_mf <= 2'h0;
    end else begin
      state   <= next_state;
      ilas_mf <= (state == JTF_ILAS && mf_end) ? ilas_mf + 2'h1 :
                 (state == JTF_ILAS) ? ilas_mf : 2'h0;
    end
  end

  // Tail sequence steps once a character
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prbs <= `JTF_PRBS_SEED;
    end else begin
      prbs <= {prbs[13:0], prbs[14] ^ prbs[13]};
    end
  end

  // Frame words are latched at the last octet for use by the next frame
  assign frame_take = f_last;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < WORDS; i++) begin
        wbuf[i] <= 16'h0000;
      end
    end else if (frame_take) begin
      for (int i = 0; i < WORDS; i++) begin
        wbuf[i] <= frame_word[i];
      end
    end
  end

  // Per-lane octet selection, ILAS, alignment and coding
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    jtf_lane_if lif ();
    logic [7:0] prev_last;

    // Lane l carries octets l*F .. l*F+F-1 of the frame
    wire [6:0] idx  = 7'(7'(l) << f_log) + {3'h0, f_cnt};
    wire [5:0] widx = np16 ? idx[6:1] : idx[5:0];
    wire [5:0] bidx = widx ^ {5'h00, swap};
    wire [2:0] conv = bidx[2:0] & 3'(mm1);
    wire       act  = (l >> l_log) == 0;

    wire jtf_word_type word = jtf_pack(wbuf[bidx], conv_flags[conv], prbs,
                                       n_m1, cs, tail_prbs);
    wire [7:0] dat = (np16 && idx[0]) ? word[7:0] : word[15:8];

    // ILAS: R at start, A at end, Q and configuration in the second
    wire [8:0] pos  = 9'({4'h0, k_cnt} << f_log) + {5'h00, f_cnt};
    wire       i_r  = pos == 9'h000;
    wire       i_q  = ilas_mf == 2'h1 && pos == 9'h001;
    wire       i_c  = ilas_mf == 2'h1 && pos >= 9'h002 && pos <= 9'h00f;
    wire [7:0] lid  = 8'(l);
    wire [7:0] cfgv = pos == 9'h004 ? lid : pos == 9'h005 ? c_l :
                      pos == 9'h006 ? {4'h0, f_max} : pos == 9'h007 ? {3'h0, k_max} :
                      pos == 9'h008 ? {3'h0, mm1} : pos == 9'h009 ? c_n :
                      pos == 9'h00a ? c_np : pos == 9'h00b ? c_s :
                      pos == 9'h00c ? c_hd : pos == 9'h00f ? c_sum + lid : 8'h00;
    wire [7:0] ioct = mf_end ? `JTF_K_A : i_r ? `JTF_K_R : i_q ? `JTF_K_Q :
                      i_c ? cfgv : pos[7:0];
    wire       ik   = mf_end || i_r || i_q;

    // Scrambling covers user data only; ILAS goes out plain
    assign lif.octet  = (state == JTF_DATA) ? dat : 8'h00;
    assign lif.scr_on = scr_en;
    assign lif.adv    = state == JTF_DATA;

    jtf_scrambler u_scr (
      .clk  (clk),
      .rstn (rstn),
      .lane (lif.scram)
    );

    // Alignment characters replace matching octets at boundaries
    wire [7:0] sd    = lif.scr_octet;
    wire       rep_a = faci && mf_end &&
                       (scr_en ? sd == `JTF_D_7C : sd == prev_last);
    wire       rep_f = faci && f_last && !rep_a &&
                       (scr_en ? sd == `JTF_D_FC : sd == prev_last);
    wire [7:0] dchr  = rep_a ? `JTF_K_A : rep_f ? `JTF_K_F : sd;

    // Synchronization and idle lanes send commas only
    assign lif.chr  = (state == JTF_CGS || !act) ? `JTF_K_K :
                      (state == JTF_ILAS) ? ioct : dchr;
    assign lif.is_k = (state == JTF_CGS || !act) ? 1'b1 :
                      (state == JTF_ILAS) ? ik : (rep_a || rep_f);

    // Last data octet of each frame, kept even when replaced
    always_ff @(posedge clk) begin
      if (!rstn) begin
        prev_last <= 8'h00;
      end else if (state == JTF_DATA && f_last) begin
        prev_last <= sd;
      end
    end

    jtf_enc8b10b u_enc (
      .clk  (clk),
      .rstn (rstn),
      .lane (lif.enc)
    );

    assign sym[l]         = lif.symbol;
    assign lane_active[l] = act;
  end

  // Ten bits per character clock; the serializer sets the lane rate
  assign serial_lane_0 = sym[0];
  assign serial_lane_1 = sym[1];
  assign serial_lane_2 = sym[2];
  assign serial_lane_3 = sym[3];
endmodule // jtf_framer

/* rtl/jtf_regs.svh */
/*
  Register offsets, field positions, reset values and character codes of the
  transmit link framer. Assumes inclusion by bare name from the rtl folder.
*/
`ifndef JTF_REGS_SVH
`define JTF_REGS_SVH
// How it works
// - Link runs on one, two or four lanes.
// - One, two, four or eight converters per link.
// - Frames are 1, 2, 4, 8 or 16 octets long.
// - Sample word size is 8 or 16 bits.
// - Converter resolution may be set from 7 to 16 bits.
// - Zero to three control bits are appended per sample.
// - Multiframe holds 4 to 32 frames in steps of four.
// - Samples per frame and high density derive from lanes, converters, octets, word size.
// - Control words per frame clock are always zero.
// - After reset, two converters over four lanes.
// - Default mapping puts converter A on lanes 0-1, B on lanes 2-3.
// - Quick setting folds the link onto lane 0 with F unchanged, or swaps A and B.
// - First octet of a 14-bit sample holds bits 13 down to 6.
// - Second octet holds bits 5 down to 0, then two tail bits.
// - Tail bits are zeros or pseudorandom, by setting.
// - Control bits carry overrange, sysref capture or fast detect instead of tail.
// - Scrambling can be switched on or off.
// - Scrambler is self-synchronizing 1 + x^14 + x^15; receiver descrambles to match.
// - Each octet becomes one 10-bit symbol via 8b/10b encoding.
// - Each lane runs up to 12.5 Gbps; receiver accepts that rate.
// - Special characters sent at link start and kept in the stream afterwards.
// - Tail bits equal word size minus resolution minus control bits.
// - Scrambled 0xFC at frame end becomes /F/, 0x7C at multiframe end /A/.
// - During code group synchronization every lane sends only K28.5.

// Register byte offsets
`define JTF_OFF_LINK 8'h00
`define JTF_OFF_CTRL 8'h04
`define JTF_OFF_STAT 8'h08

// Link register: lanes, converters, octets as log2, word size, N-1, CS, K code
`define JTF_L_L    1:0
`define JTF_L_M    3:2
`define JTF_L_F    6:4
`define JTF_L_NP   7
`define JTF_L_N    11:8
`define JTF_L_CS   13:12
`define JTF_L_K    18:16
`define JTF_LINK_RST  32'h0007_0d86
`define JTF_LINK_MASK 32'h0007_3fff

// Control register
`define JTF_C_SCR    0
`define JTF_C_PRBS   1
`define JTF_C_FACI   2
`define JTF_C_QUICK  5:4
`define JTF_C_RELINK 8
`define JTF_CTRL_RST  32'h0000_0005
`define JTF_CTRL_MASK 32'h0000_0037

// Status register
`define JTF_S_STATE 1:0
`define JTF_S_ERR   2
`define JTF_S_S     6:4
`define JTF_S_HD    7
`define JTF_S_SYNC  8

// Control characters and data match values
`define JTF_K_R  8'h1c
`define JTF_K_A  8'h7c
`define JTF_K_Q  8'h9c
`define JTF_K_K  8'hbc
`define JTF_K_F  8'hfc
`define JTF_D_FC 8'hfc
`define JTF_D_7C 8'h7c

// Seeds and sequence lengths
`define JTF_SCR_SEED  15'h0000
`define JTF_PRBS_SEED 15'h7fff
`define JTF_ILAS_LAST 2'h3
`endif

/* rtl/jtf_pkg.sv */
/*
  Types shared by the framer modules. Assumes nothing beyond SystemVerilog.
*/
package jtf_pkg;
  typedef enum logic [1:0] {
    JTF_CGS  = 2'b00,
    JTF_ILAS = 2'b01,
    JTF_DATA = 2'b10
  } jtf_state_type;

  typedef enum logic [1:0] {
    JTF_Q_DEF  = 2'b00,
    JTF_Q_ONE  = 2'b01,
    JTF_Q_SWAP = 2'b10
  } jtf_quick_type;

  typedef logic [15:0] jtf_word_type;
endpackage

/* rtl/jtf_lane_if.sv */
/*
  Per-lane carrier between the framer, its scrambler and its encoder.
  Assumes the framer drives octet, control and character signals.
*/
`timescale 1ns/10ps
interface jtf_lane_if;
  logic [7:0] octet;
  logic       scr_on;
  logic       adv;
  logic [7:0] scr_octet;
  logic [7:0] chr;
  logic       is_k;
  logic [9:0] symbol;

  modport scram (input octet, scr_on, adv, output scr_octet);
  modport enc   (input chr, is_k, output symbol);
endinterface

/* rtl/jtf_scrambler.sv */
/*
  Self-synchronizing octet scrambler, MSB first.
  Assumes adv marks octets that belong to the scrambled stream.
*/
`timescale 1ns/10ps
`include "jtf_regs.svh"
module jtf_scrambler (
  input wire logic  clk,   // Character clock
  input wire logic  rstn,  // Synchronous reset, active low
  jtf_lane_if.scram lane   // Octet in, scrambled octet out
);
  logic [14:0] hist;
  logic [14:0] next_hist;
  logic [7:0]  outb;

  // Each output bit folds in the outputs 14 and 15 bits back
  always_comb begin
    next_hist = hist;
    outb      = lane.octet;
    for (int i = 7; i >= 0; i--) begin
      outb[i]   = lane.octet[i] ^ next_hist[13] ^ next_hist[14];
      next_hist = {next_hist[13:0], outb[i]};
    end
  end

  assign lane.scr_octet = lane.scr_on ? outb : lane.octet;

  // History only moves with scrambled data, so ILAS leaves it alone
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hist <= `JTF_SCR_SEED;
    end else if (lane.adv && lane.scr_on) begin
      hist <= next_hist;
    end
  end
endmodule // jtf_scrambler

/* rtl/jtf_enc8b10b.sv */
/*
  8b/10b encoder with running disparity, registered symbol output.
  Assumes is_k is only set for K28.x characters.
*/
`timescale 1ns/10ps
module jtf_enc8b10b (
  input wire logic clk,   // Character clock
  input wire logic rstn,  // Synchronous reset, active low
  jtf_lane_if.enc  lane   // Character in, symbol out
);
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  logic rd;  // High for positive running disparity
  logic [9:0] sym;

  // 5b/6b stage; tables hold the negative-disparity form
  wire [4:0] x5 = lane.chr[4:0];
  wire [2:0] y3 = lane.chr[7:5];
  wire [5:0] b6 = lane.is_k ? 6'h0f : T6[x5];
  wire       u6 = $countones(b6) != 3;
  wire       d7 = !lane.is_k && x5 == 5'h07;
  wire [5:0] o6 = (rd && (u6 || d7)) ? ~b6 : b6;
  wire       rd_mid = u6 ? ~rd : rd;

  // 3b/4b stage; alternate x.7 avoids five equal bits in a row
  wire a_neg = x5 == 5'h11 || x5 == 5'h12 || x5 == 5'h14;
  wire a_pos = x5 == 5'h0b || x5 == 5'h0d || x5 == 5'h0e;
  wire alt7 = y3 == 3'h7 && (lane.is_k || (!rd_mid && a_neg) || (rd_mid && a_pos));
  wire [3:0] b4 = alt7 ? 4'h7 : T4[y3];
  wire       u4 = $countones(b4) != 2;
  wire       inv4 = u4 ? rd_mid : (y3 == 3'h3) ? rd_mid : (lane.is_k & ~rd_mid);
  wire [3:0] o4 = inv4 ? ~b4 : b4;

  // Symbol and disparity update every character
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd  <= 1'b0;
      sym <= 10'h000;
    end else begin
      rd  <= u4 ? ~rd_mid : rd_mid;
      sym <= {o6, o4};
    end
  end

  assign lane.symbol = sym;
endmodule // jtf_enc8b10b

/* verification/jtf_framer_checker.sv */
/*
  Port checker of the transmit link framer.
  Assumes the default link setup (F*K of 32) whenever the link is brought up.
*/
`timescale 1ns/10ps
module jtf_framer_checker (
  input wire logic        clk,           // Character clock
  input wire logic        rstn,          // Sync reset, low
  input wire logic [7:0]  reg_addr,      // Register address
  input wire logic        reg_rd,        // Read strobe
  input wire logic [31:0] reg_rdata,     // Read data
  input wire logic        sync_req_n,    // Receiver sync, low
  input wire logic [3:0]  lane_active,   // Lanes in use
  input wire logic [9:0]  serial_lane_0, // Lane 0 symbol
  input wire logic [9:0]  serial_lane_1, // Lane 1 symbol
  input wire logic [9:0]  serial_lane_2, // Lane 2 symbol
  input wire logic [9:0]  serial_lane_3  // Lane 3 symbol
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Comma in either running disparity
  function automatic logic is_k(input logic [9:0] s);
    return s == 10'h0fa || s == 10'h305;
  endfunction

  // Steps of link start: request held, multiframe opened, multiframe closed
  sequence sync_held;
    !sync_req_n [*2];
  endsequence
  sequence mf_open;
    serial_lane_0 == 10'h0f4 || serial_lane_0 == 10'h30b;
  endsequence
  sequence mf_close;
    serial_lane_0 == 10'h0f3 || serial_lane_0 == 10'h30c;
  endsequence

  lane_count_a: assert property (lane_active inside {4'h1, 4'h3, 4'hf})
    else $error("lane enables not one, two or four lanes");
  cgs_comma_a: assert property (sync_held |=> is_k(serial_lane_0) && is_k(serial_lane_1)
    && is_k(serial_lane_2) && is_k(serial_lane_3))
    else $error("lane not sending commas while sync is requested");
  idle_lane_a: assert property (!lane_active[3] [*2] |-> is_k(serial_lane_3))
    else $error("unused lane 3 not sending commas");
  ilas_start_a: assert property ($rose(sync_req_n) |-> ##[1:600] mf_open)
    else $error("no start of multiframe after sync release");
  ilas_close_a: assert property (mf_open ##0 lane_active == 4'hf |-> ##31 mf_close)
    else $error("multiframe not closed by lane alignment character");
  status_cgs_a: assert property (reg_rd && reg_addr == 8'h08 && !sync_req_n
    && !$past(sync_req_n) |=> reg_rdata[1:0] == 2'b00)
    else $error("status shows no sync phase while sync is requested");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  unmapped_rd_a: assert property (reg_rd && !(reg_addr inside {8'h00, 8'h04, 8'h08})
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
endmodule // jtf_framer_checker

/* verification/jtf_rx_model.sv */
/*
  Link receiver model: requests sync until it sees enough commas on lane 0.
  Assumes the bench holds it in request while the link setup changes.
*/
`timescale 1ns/10ps
module jtf_rx_model (
  input wire logic       clk,        // Character clock
  input wire logic       rstn,       // Sync reset, low
  input wire logic       hold,       // Keep requesting sync
  input wire logic       slow,       // Need sixteen commas, not four
  input wire logic [9:0] lane_sym,   // Lane 0 symbol
  output logic           sync_req_n  // Sync request, low
);
  logic [4:0] k_run;                  // Commas seen in a row
  wire        is_comma = lane_sym == 10'h0fa || lane_sym == 10'h305;
  wire  [4:0] need     = slow ? 5'h10 : 5'h04;

  // Release only on an unbroken comma run, with the framer's own setup
  always_ff @(posedge clk) begin
    if (!rstn || hold) begin
      k_run      <= 5'h00;
      sync_req_n <= 1'b0;
    end else if (!sync_req_n) begin
      k_run      <= is_comma ? k_run + 5'h01 : 5'h00;
      sync_req_n <= is_comma && (k_run + 5'h01 >= need);
    end
  end
endmodule // jtf_rx_model

/* verification/tb_jesd_tx_transport_framer.sv */
/*
  Self-checking bench of the transmit link framer with a receiver model.
  Assumes one 10 MHz clock and constant frame words from the bench.
*/
`timescale 1ns/10ps
module tb_jesd_tx_transport_framer;
  import jtf_pkg::*;
  logic         clk, rstn, reg_wr, reg_rd, hold, slow, sync_req_n, frame_take;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, d;
  logic [3:0]   lane_active;
  logic [9:0]   serial_lane_0, serial_lane_1, serial_lane_2, serial_lane_3;
  jtf_word_type frame_word [64];
  logic [2:0]   conv_flags [8];
  int           n_errors, comparisons;

  jtf_framer uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_word(frame_word),
    .conv_flags(conv_flags), .frame_take(frame_take), .sync_req_n(sync_req_n),
    .lane_active(lane_active), .serial_lane_0(serial_lane_0),
    .serial_lane_1(serial_lane_1), .serial_lane_2(serial_lane_2),
    .serial_lane_3(serial_lane_3));
  jtf_rx_model rx (.clk(clk), .rstn(rstn), .hold(hold), .slow(slow),
    .lane_sym(serial_lane_0), .sync_req_n(sync_req_n));

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Symbols may come in either running disparity
  task automatic cmp_sym(input string what, input logic [9:0] a, input logic [9:0] b,
                         input logic [9:0] got);
    comparisons++;
    if (got !== a && got !== b) begin
      n_errors++;
      $display("[ERR] %s expected %h or %h seen %h", what, a, b, got);
    end
  endtask

  task automatic skip(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  // Setup only changes under a held sync request, then a forced relink; ends on /R/
  task automatic link_up(input logic [31:0] ctrl, input logic [31:0] link);
    hold <= 1'b1;
    wr(8'h00, link);
    wr(8'h04, ctrl | 32'h0000_0100);
    @(posedge clk);
    hold <= 1'b0;
    for (int i = 0; i < 900; i++) begin
      @(negedge clk);
      if (serial_lane_0 == 10'h0f4 || serial_lane_0 == 10'h30b)
        return;
    end
    n_errors++;
    report_and_stop();
  endtask

  task automatic t_reg_reset;
    rd(8'h00, d);
    cmp_val("link reset", 32'h0007_0d86, d);
    rd(8'h04, d);
    cmp_val("ctrl reset", 32'h0000_0005, d);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, d);
    cmp_val("unmapped read", 32'h0, d);
    rd(8'h00, d);
    cmp_val("link after stray write", 32'h0007_0d86, d);
  endtask

  task automatic t_derive;
    logic [31:0] cfg [6] = '{32'h0000_0d90, 32'h0003_0722, 32'h0001_0605,
                             32'h0006_0dce, 32'h0007_1f86, 32'h0007_0d86};
    logic [4:0]  sts [6] = '{5'h00, 5'h08, 5'h00, 5'h04, 5'h00, 5'h10};
    logic [3:0]  las [6] = '{4'h1, 4'hf, 4'h3, 4'hf, 4'h0, 4'hf};
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, cfg[i]);
      rd(8'h00, d);
      cmp_val("link readback", cfg[i], d);
      rd(8'h08, d);
      if (las[i] == 4'h0) begin
        cmp_val("config error", 32'h1, d[2]);
      end else begin
        cmp_val("derived s and hd", sts[i], {d[7:4], d[2]});
        cmp_val("lane enables", las[i], lane_active);
      end
    end
  endtask

  task automatic t_ilas_data;
    link_up(32'h0, 32'h0007_0d86);
    skip(31);
    cmp_sym("ilas end", 10'h0f3, 10'h30c, serial_lane_0);
    skip(2);
    cmp_sym("config marker", 10'h0f2, 10'h30d, serial_lane_0);
    skip(11);
    cmp_sym("control words", 10'h272, 10'h18d, serial_lane_0);
    skip(84);
    cmp_sym("lane 0 data", 10'h319, 10'h319, serial_lane_0);
    cmp_sym("lane 1 data", 10'h0d9, 10'h0d9, serial_lane_1);
    cmp_sym("lane 2 data", 10'h295, 10'h295, serial_lane_2);
    cmp_sym("lane 3 data", 10'h0b5, 10'h0b5, serial_lane_3);
    cmp_val("frame take", 32'h1, frame_take);
  endtask

  task automatic t_faci;
    link_up(32'h4, 32'h0007_0d86);
    skip(129);
    cmp_sym("frame align", 10'h0f8, 10'h307, serial_lane_0);
    skip(30);
    cmp_sym("lane align", 10'h0f3, 10'h30c, serial_lane_0);
    rd(8'h08, d);
    cmp_val("data state", 32'h2, d[1:0]);
  endtask

  task automatic t_swap;
    slow <= 1'b1;
    link_up(32'h20, 32'h0007_0d86);
    skip(128);
    cmp_sym("swapped lane 0", 10'h295, 10'h295, serial_lane_0);
    cmp_sym("swapped lane 2", 10'h319, 10'h319, serial_lane_2);
    hold <= 1'b1;
    slow <= 1'b0;
    wr(8'h04, 32'h10);
    skip(1);
    cmp_val("one lane enables", 32'h1, lane_active);
  endtask

  // Zero seed lets the first two octets pass as they are
  task automatic t_scramble;
    link_up(32'h1, 32'h0007_0d86);
    skip(128);
    cmp_sym("first scrambled", 10'h319, 10'h319, serial_lane_0);
    skip(2);
    cmp_sym("third scrambled", 10'h25e, 10'h251, serial_lane_0);
  endtask

  task automatic t_prbs;
    logic [9:0] first;
    logic       moved;
    link_up(32'h2, 32'h0007_0d86);
    skip(128);
    first = serial_lane_1;
    moved = 1'b0;
    repeat (8) begin
      skip(1);
      if (serial_lane_1 !== first)
        moved = 1'b1;
    end
    cmp_val("tail pattern moving", 32'h1, moved);
  endtask

  task automatic t_ctrl_bits;
    @(posedge clk) conv_flags[0] <= 3'b001;
    link_up(32'h0, 32'h0007_1d86);
    skip(128);
    cmp_sym("overrange bit", 10'h1c9, 10'h1c9, serial_lane_1);
    cmp_sym("sample untouched", 10'h319, 10'h319, serial_lane_0);
  endtask

  task automatic t_resync;
    hold <= 1'b1;
    skip(3);
    cmp_sym("resync comma", 10'h0fa, 10'h305, serial_lane_2);
    rd(8'h08, d);
    cmp_val("resync state", 32'h0, d[1:0]);
  endtask

  // Main sequence
  initial begin
    rstn       = 1'b0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    hold       = 1'b1;
    slow       = 1'b0;
    frame_word = '{default: 16'h0000};
    conv_flags = '{default: 3'b000};
    frame_word[0] = 16'h232c;
    frame_word[1] = 16'h4554;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reg_reset();
    t_derive();
    t_ilas_data();
    t_faci();
    t_swap();
    t_scramble();
    t_prbs();
    t_ctrl_bits();
    t_resync();
    report_and_stop();
  end
endmodule // tb_jesd_tx_transport_framer

bind jtf_framer jtf_framer_checker chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_req_n(sync_req_n),
  .lane_active(lane_active), .serial_lane_0(serial_lane_0),
  .serial_lane_1(serial_lane_1), .serial_lane_2(serial_lane_2),
  .serial_lane_3(serial_lane_3));
